// *** src/timer_ch4_io_control.sv ***
// Purpose: channel 4 timer I/O control with AXI4-Lite register access
// Assumes: counter value and pin inputs synchronous to clk_sys
// Notes:   four general registers, each set up by a 4-bit function field
//
// Notes on behaviour
// - high control register bits 7..4 set the function of general register B.
// - high control register bits 3..0 set the function of general register A.
// - low control register bits 7..4 set the function of general register D.
// - low control register bits 3..0 set the function of general register C.
// - code 0000 is compare with pin output off; every field resets to it.
// - codes 0001-0011 start the pin at 0; match drives 0, 1 or toggles.
// - code 0100 stays compare but keeps the pin output off.
// - codes 0101-0111 start the pin at 1; match drives 0, 1 or toggles.
// - codes 1000 and 1100 capture on a rising pin edge.
// - codes 1001 and 1101 capture on a falling pin edge.
// - codes 1010, 1011, 1110, 1111 capture on both pin edges.
// - each general register captures from its own timer pin, A to A through D.
// - buffer mode B set makes field D ineffective; no capture or compare on D.
// - buffer mode A set makes field C ineffective; no capture or compare on C.
`timescale 1ns/100ps
`default_nettype none
module timer_ch4_io_control
   import timer_io_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // axi4-lite write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [DATA_W-1:0] s_axi_wdata,
   input wire logic [DATA_W/8-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // channel counter value
   input wire logic [CNT_W-1:0] count_in,
   // timer pins a..d, bit 0 is pin a
   input wire logic [NUM_GR-1:0] timer_pin_in,
   output wire logic [NUM_GR-1:0] timer_pin_out,
   output wire logic [NUM_GR-1:0] timer_pin_oe
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------

   // address decode, shared by the write and the read path
   function automatic reg_sel_t reg_select(input logic [ADDR_W-1:0] addr);
      reg_sel_t sel;
      case (addr)
         OFF_CTL_HI: sel = SEL_CTL_HI;
         OFF_CTL_LO: sel = SEL_CTL_LO;
         OFF_MODE: sel = SEL_MODE;
         OFF_GR_A: sel = SEL_GR_A;
         OFF_GR_B: sel = SEL_GR_B;
         OFF_GR_C: sel = SEL_GR_C;
         OFF_GR_D: sel = SEL_GR_D;
         OFF_STATUS: sel = SEL_STATUS;
         default: sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   // byte-lane merge for the counter-wide general registers
   function automatic logic [CNT_W-1:0] merge_lanes(input logic [CNT_W-1:0] old,
                                                     input logic [DATA_W-1:0] data,
                                                     input logic [DATA_W/8-1:0] strb);
      logic [CNT_W-1:0] res;
      res = old;
      for (int b = 0; b < CNT_W / 8; b++) begin
         if (strb[b]) begin
            res[b*8 +: 8] = data[b*8 +: 8];
         end
      end
      return res;
   endfunction

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   logic aw_held_q, aw_held_d, w_held_q, w_held_d;
   logic awready_q, awready_d, wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [DATA_W/8-1:0] wstrb_q, wstrb_d;
   logic [CTL_W-1:0] ctl_hi_q, ctl_hi_d, ctl_lo_q, ctl_lo_d;
   logic [MODE_W-1:0] mode_q, mode_d;
   logic [NUM_GR-1:0] cfg_load_q, cfg_load_d;
   logic wr_fire;
   reg_sel_t wr_sel, rd_sel;
   logic arready_q, arready_d, rvalid_q, rvalid_d;
   logic [1:0] rresp_q, rresp_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic [CNT_W-1:0] gr_val [NUM_GR];
   logic [NUM_GR-1:0] pin_out_w, pin_oe_w, cap_use_w;
   logic [2*CTL_W-1:0] fields_w;

   // fields a..d packed in order: a = hi[3:0], b = hi[7:4], c = lo[3:0], d = lo[7:4]
   assign fields_w = {ctl_lo_q, ctl_hi_q};

   // -----------------------------------------------------------------
   // general register units
   // -----------------------------------------------------------------
   gr_chan_if #(.W(CNT_W)) u_if [NUM_GR] ();

   genvar g;
   generate
      for (g = 0; g < NUM_GR; g++) begin : gen_gr
         assign u_if[g].field = fields_w[g*FIELD_W +: FIELD_W];
         assign u_if[g].inhibit = (g == GR_C_IDX) ? mode_q[MODE_BUF_A_BIT] :
                                  (g == GR_D_IDX) ? mode_q[MODE_BUF_B_BIT] : 1'b0;
         assign u_if[g].cfg_load = cfg_load_q[g];
         assign u_if[g].gr_wr = wr_fire && (wr_sel == reg_sel_t'(SEL_GR_A + g));
         assign u_if[g].wr_data = merge_lanes(gr_val[g], wdata_q, wstrb_q);
         assign u_if[g].count = count_in;
         assign u_if[g].pin_in = timer_pin_in[g];
         assign gr_val[g] = u_if[g].gr_value;
         assign pin_out_w[g] = u_if[g].pin_out;
         assign pin_oe_w[g] = u_if[g].pin_oe;
         assign cap_use_w[g] = fields_w[g*FIELD_W + FLD_CAPTURE_BIT];

         gr_channel u_ch (
            .clk_sys(clk_sys),
            .reset(reset),
            .ch(u_if[g].unit)
         );
      end
   endgenerate

   // pins come straight from the unit flip-flops
   assign timer_pin_out = pin_out_w;
   assign timer_pin_oe = pin_oe_w;

   // -----------------------------------------------------------------
   // write path and control registers
   // -----------------------------------------------------------------

   // address and data are taken independently; the write happens once both are held
   assign wr_sel = reg_select(awaddr_q);
   assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      ctl_hi_d = ctl_hi_q;
      ctl_lo_d = ctl_lo_q;
      mode_d = mode_q;
      cfg_load_d = '0;
      if (s_axi_awvalid && awready_q) begin
         aw_held_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_q) begin
         w_held_d = 1'b1;
         wdata_d = s_axi_wdata;
         wstrb_d = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (wr_fire) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
         // only byte lane 0 reaches the 8-bit registers
         if (wstrb_q[0]) begin
            case (wr_sel)
               SEL_CTL_HI: begin
                  ctl_hi_d = wdata_q[CTL_W-1:0];
                  cfg_load_d[0] = 1'b1;
                  cfg_load_d[1] = 1'b1;
               end
               SEL_CTL_LO: begin
                  ctl_lo_d = wdata_q[CTL_W-1:0];
                  cfg_load_d[GR_C_IDX] = 1'b1;
                  cfg_load_d[GR_D_IDX] = 1'b1;
               end
               SEL_MODE: mode_d = wdata_q[MODE_W-1:0];
               default: mode_d = mode_q;
            endcase
         end
      end
      // a channel holds off its ready while its word is parked or a response waits
      awready_d = !aw_held_d && !bvalid_d;
      wready_d = !w_held_d && !bvalid_d;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         ctl_hi_q <= CTL_RESET;
         ctl_lo_q <= CTL_RESET;
         mode_q <= '0;
         cfg_load_q <= '0;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         ctl_hi_q <= ctl_hi_d;
         ctl_lo_q <= ctl_lo_d;
         mode_q <= mode_d;
         cfg_load_q <= cfg_load_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------

   // data is sampled at the address handshake, so a read never sees a half update
   assign rd_sel = reg_select(s_axi_araddr);

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      if (s_axi_arvalid && arready_q) begin
         rvalid_d = 1'b1;
         rresp_d = RESP_OKAY;
         rdata_d = '0;
         case (rd_sel)
            SEL_CTL_HI: rdata_d[CTL_W-1:0] = ctl_hi_q;
            SEL_CTL_LO: rdata_d[CTL_W-1:0] = ctl_lo_q;
            SEL_MODE: rdata_d[MODE_W-1:0] = mode_q;
            SEL_GR_A: rdata_d[CNT_W-1:0] = gr_val[0];
            SEL_GR_B: rdata_d[CNT_W-1:0] = gr_val[1];
            SEL_GR_C: rdata_d[CNT_W-1:0] = gr_val[GR_C_IDX];
            SEL_GR_D: rdata_d[CNT_W-1:0] = gr_val[GR_D_IDX];
            SEL_STATUS: begin
               rdata_d[STAT_OUT_LSB +: NUM_GR] = pin_out_w;
               rdata_d[STAT_OE_LSB +: NUM_GR] = pin_oe_w;
               rdata_d[STAT_CAP_LSB +: NUM_GR] = cap_use_w;
            end
            default: rresp_d = RESP_SLVERR;
         endcase
      end
      // one read in flight: address ready only while no data waits
      arready_d = !rvalid_d;
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

// *** pkg/timer_io_pkg.sv ***
// Purpose: shared constants and types for the channel 4 timer I/O control block
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   narrow registers sit in the low bits; upper bits read as zero
package timer_io_pkg;
   // -----------------------------------------------------------------
   // sizes
   // -----------------------------------------------------------------
   localparam int CNT_W = 16;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int NUM_GR = 4;
   localparam int FIELD_W = 4;
   localparam int CTL_W = 8;

   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFF_CTL_HI = 8'h00;
   localparam logic [7:0] OFF_CTL_LO = 8'h04;
   localparam logic [7:0] OFF_MODE = 8'h08;
   localparam logic [7:0] OFF_GR_A = 8'h10;
   localparam logic [7:0] OFF_GR_B = 8'h14;
   localparam logic [7:0] OFF_GR_C = 8'h18;
   localparam logic [7:0] OFF_GR_D = 8'h1C;
   localparam logic [7:0] OFF_STATUS = 8'h20;

   // -----------------------------------------------------------------
   // field layouts and reset values
   // -----------------------------------------------------------------
   localparam logic [CTL_W-1:0] CTL_RESET = 8'h00;
   localparam logic [CNT_W-1:0] GR_RESET = 16'hFFFF;
   localparam int FLD_CAPTURE_BIT = 3;
   localparam int FLD_INIT_BIT = 2;
   localparam int FLD_BOTH_BIT = 1;
   localparam int FLD_FALL_BIT = 0;
   localparam int MODE_BUF_A_BIT = 0;
   localparam int MODE_BUF_B_BIT = 1;
   localparam int MODE_W = 2;
   localparam int STAT_OUT_LSB = 0;
   localparam int STAT_OE_LSB = 4;
   localparam int STAT_CAP_LSB = 8;
   localparam int GR_C_IDX = 2;
   localparam int GR_D_IDX = 3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {ACT_NONE = 2'b00, ACT_CLR = 2'b01, ACT_SET = 2'b10, ACT_TGL = 2'b11} act_t;
   typedef enum logic [1:0] {EDGE_RISE = 2'b00, EDGE_FALL = 2'b01, EDGE_BOTH = 2'b10} edge_sel_t;
   typedef struct packed {
      logic capture;
      logic drive;
      logic init;
      act_t act;
      edge_sel_t edge_sel;
   } io_func_t;
   typedef enum logic [3:0] {
      SEL_CTL_HI = 4'h0, SEL_CTL_LO = 4'h1, SEL_MODE = 4'h2, SEL_GR_A = 4'h3,
      SEL_GR_B = 4'h4, SEL_GR_C = 4'h5, SEL_GR_D = 4'h6, SEL_STATUS = 4'h7, SEL_NONE = 4'hF
   } reg_sel_t;
endpackage

// *** pkg/gr_chan_if.sv ***
// Purpose: carrier between the register front end and one general register unit
// Assumes: single clock domain
// Notes:   ctrl side drives configuration and strobes, unit side returns state
`timescale 1ns/100ps
`default_nettype none
interface gr_chan_if #(parameter int W = 16);
   logic [3:0] field;
   logic inhibit;
   logic cfg_load;
   logic gr_wr;
   logic [W-1:0] wr_data;
   logic [W-1:0] count;
   logic pin_in;
   logic [W-1:0] gr_value;
   logic pin_out;
   logic pin_oe;
   modport ctrl (output field, inhibit, cfg_load, gr_wr, wr_data, count, pin_in,
                 input gr_value, pin_out, pin_oe);
   modport unit (input field, inhibit, cfg_load, gr_wr, wr_data, count, pin_in,
                 output gr_value, pin_out, pin_oe);
endinterface
`default_nettype wire

// *** src/io_function_decode.sv ***
// Purpose: turn a 4-bit function field into compare / capture settings
// Assumes: purely combinational
// Notes:   capture codes with bit 2 set alias the ones without it
`timescale 1ns/100ps
`default_nettype none
module io_function_decode
   import timer_io_pkg::*;
(
   // field in
   input wire logic [FIELD_W-1:0] field,
   // decoded settings
   output io_func_t func
);
   // -----------------------------------------------------------------
   // decode
   // -----------------------------------------------------------------
   always_comb begin
      func = '0;
      func.capture = field[FLD_CAPTURE_BIT];
      if (field[FLD_CAPTURE_BIT]) begin
         if (field[FLD_BOTH_BIT]) begin
            func.edge_sel = EDGE_BOTH;
         end else if (field[FLD_FALL_BIT]) begin
            func.edge_sel = EDGE_FALL;
         end else begin
            func.edge_sel = EDGE_RISE;
         end
      end else begin
         func.init = field[FLD_INIT_BIT];
         func.act = act_t'(field[FLD_BOTH_BIT:FLD_FALL_BIT]);
         func.drive = (field[FLD_BOTH_BIT:FLD_FALL_BIT] != 2'h0);
      end
   end
endmodule
`default_nettype wire

// *** src/gr_channel.sv ***
// Purpose: one general register with its compare output and capture input
// Assumes: counter and pin inputs synchronous to clk_sys
// Notes:   compare acts once when equality begins, not every cycle it lasts
`timescale 1ns/100ps
`default_nettype none
module gr_channel
   import timer_io_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // link to front end
   gr_chan_if.unit ch
);
   io_func_t func;
   logic [CNT_W-1:0] gr_q, gr_d;
   logic pin_q, pin_d, oe_q, oe_d, in_prev_q, eq_prev_q, eq_d;
   logic hit, cap, rise, fall;

   io_function_decode u_dec (
      .field(ch.field),
      .func(func)
   );

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      eq_d = !func.capture && (ch.count == gr_q);
      hit = eq_d && !eq_prev_q && !ch.inhibit;
      rise = ch.pin_in && !in_prev_q;
      fall = !ch.pin_in && in_prev_q;
      cap = 1'b0;
      if (func.capture && !ch.inhibit) begin
         case (func.edge_sel)
            EDGE_RISE: cap = rise;
            EDGE_FALL: cap = fall;
            EDGE_BOTH: cap = rise || fall;
            default: cap = 1'b0;
         endcase
      end
      gr_d = gr_q;
      if (ch.gr_wr) begin
         gr_d = ch.wr_data;
      end
      // a capture beats a software write in the same cycle
      if (cap) begin
         gr_d = ch.count;
      end
      pin_d = pin_q;
      if (ch.cfg_load && !func.capture) begin
         pin_d = func.init;
      end else if (hit) begin
         case (func.act)
            ACT_CLR: pin_d = 1'b0;
            ACT_SET: pin_d = 1'b1;
            ACT_TGL: pin_d = !pin_q;
            default: pin_d = pin_q;
         endcase
      end
      oe_d = func.drive && !ch.inhibit;
   end

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         gr_q <= GR_RESET;
         pin_q <= 1'b0;
         oe_q <= 1'b0;
         in_prev_q <= 1'b0;
         eq_prev_q <= 1'b0;
      end else begin
         gr_q <= gr_d;
         pin_q <= pin_d;
         oe_q <= oe_d;
         in_prev_q <= ch.pin_in;
         eq_prev_q <= eq_d;
      end
   end

   assign ch.gr_value = gr_q;
   assign ch.pin_out = pin_q;
   assign ch.pin_oe = oe_q;
endmodule
`default_nettype wire

// *** tb/timer_io_monitor.sv ***
// Purpose: port checks on the channel 4 timer I/O control block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to the top module from the bench
`timescale 1ns/100ps
`default_nettype none
module timer_io_monitor
   import timer_io_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic reset,
   // register bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // counter and pins
   input wire logic [CNT_W-1:0] count_in,
   input wire logic [NUM_GR-1:0] timer_pin_out,
   input wire logic [NUM_GR-1:0] timer_pin_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   // handshakes that open a transfer
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   a_reset_quiet: assert property ($fell(reset) |-> timer_pin_oe == 4'h0 && timer_pin_out == 4'h0)
      else $error("pins active just after reset");
   a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read data late");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   a_arready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   // enables move only as a consequence of a register write
   a_oe_cause: assert property (!$stable(timer_pin_oe) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("pin enable moved without a write");
   // a level change needs a write or a fresh counter value
   a_out_cause: assert property (!$stable(timer_pin_out) |-> $past(count_in) != $past(count_in, 2)
      || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2) || $past(s_axi_bvalid, 3))
      else $error("pin level moved without cause");
endmodule
`default_nettype wire

// *** tb/timer_pin_partner.sv ***
// Purpose: far-side model of the four timer pins
// Assumes: levels change just after a rising edge
// Notes:   where the block drives a pin the wire reads back its level
`timescale 1ns/100ps
`default_nettype none
module timer_pin_partner
   import timer_io_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // level the outside puts on undriven pins
   input wire logic [NUM_GR-1:0] level_req,
   // block side of the pins
   input wire logic [NUM_GR-1:0] pin_out,
   input wire logic [NUM_GR-1:0] pin_oe,
   output logic [NUM_GR-1:0] pin_in_q = '0
);
   logic [NUM_GR-1:0] pin_in_d;
   // resolve each wire; the outside lets go while the block drives
   always_comb begin
      pin_in_d = (pin_oe & pin_out) | (~pin_oe & level_req);
   end
   // registered so the level lands just after an edge
   always_ff @(posedge clk_sys) begin
      pin_in_q <= pin_in_d;
   end
endmodule
`default_nettype wire

// *** tb/test_timer_ch4_io_control.sv ***
// Purpose: self-checking bench for the channel 4 timer I/O control block
// Assumes: bus tasks are entered just after a rising edge
// Notes:   a small model tracks general registers and pin levels
`timescale 1ns/100ps
`default_nettype none
module test_timer_ch4_io_control;
   import timer_io_pkg::*;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
   logic [DATA_W/8-1:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [CNT_W-1:0] count_in = '0;
   logic [NUM_GR-1:0] level_req = '0, timer_pin_in, timer_pin_out, timer_pin_oe;
   logic [CNT_W-1:0] gr_m [NUM_GR];
   logic [31:0] seed = 32'hEF8BD645;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;

   timer_ch4_io_control dut (
      .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .count_in, .timer_pin_in, .timer_pin_out, .timer_pin_oe);
   timer_pin_partner far_pins (.clk_sys, .level_req, .pin_out(timer_pin_out), .pin_oe(timer_pin_oe),
      .pin_in_q(timer_pin_in));
   // 250 MHz
   always #2 clk_sys = ~clk_sys;
   // watchdog: the run needs under two thousand cycles
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // ready follows the answer, so the slave must hold it
   task automatic bus_write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         s_axi_bready <= s_axi_bvalid && !s_axi_bready;
      end while (!(s_axi_bvalid && s_axi_bready));
      rs = s_axi_bresp;
   endtask

   task automatic bus_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         s_axi_rready <= s_axi_rvalid && !s_axi_rready;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      rs = s_axi_rresp;
   endtask

   // one field set, the other three back at 0
   task automatic set_field(input int r, input logic [3:0] code);
      logic [15:0] v;
      logic [31:0] d;
      logic [1:0] rs;
      v = 16'(code) << (4 * r);
      bus_write(OFF_CTL_HI, {24'h0, v[7:0]}, rs);
      bus_write(OFF_CTL_LO, {24'h0, v[15:8]}, rs);
      check("ctl_bresp", rs, RESP_OKAY);
      bus_read(r < 2 ? OFF_CTL_HI : OFF_CTL_LO, d, rs);
      check("ctl_read", d, r < 2 ? v[7:0] : v[15:8]);
      repeat (3) @(posedge clk_sys);
   endtask
   // main sequence
   initial begin
      logic [31:0] d, t;
      logic [1:0] rs;
      int init, act;
      bit hit;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (2) @(posedge clk_sys);
      bus_read(OFF_CTL_HI, d, rs);
      check("ctl_hi_rst", d, 0);
      bus_read(OFF_CTL_LO, d, rs);
      check("ctl_lo_rst", d, 0);
      // unmapped place is refused both ways
      bus_read(8'h0C, d, rs);
      check("gap_rresp", rs, RESP_SLVERR);
      bus_write(8'h0C, 32'hFFFFFFFF, rs);
      check("gap_bresp", rs, RESP_SLVERR);
      // distinct nonzero compare values so the idle count never matches
      for (int r = 0; r < NUM_GR; r++) begin
         bus_read(OFF_GR_A + 8'(4 * r), d, rs);
         check("gr_rst", d, GR_RESET);
         t = rnd();
         gr_m[r] = {t[15:2], 2'(r)} | 16'h0100;
         bus_write(OFF_GR_A + 8'(4 * r), 32'(gr_m[r]), rs);
      end
      // every compare code on every field, then one match
      for (int r = 0; r < NUM_GR; r++) begin
         for (int c = 0; c < 8; c++) begin
            set_field(r, 4'(c));
            init = c / 4;
            act = c % 4;
            check("oe", timer_pin_oe, 32'(act != 0) << r);
            if (act != 0) check("init", timer_pin_out[r], init);
            count_in <= gr_m[r];
            repeat (3) @(posedge clk_sys);
            count_in <= '0;
            if (act != 0) check("match", timer_pin_out[r], act == 3 ? 1 - init : act - 1);
         end
      end
      set_field(0, 4'h0);
      // capture codes: each pin edge against the chosen sense
      for (int r = 0; r < NUM_GR; r++) begin
         for (int c = 8; c < 16; c++) begin
            set_field(r, 4'(c));
            repeat (2) begin
               t = rnd();
               count_in <= t[15:0];
               level_req[r] <= ~level_req[r];
               repeat (4) @(posedge clk_sys);
               hit = c[1] || (c[0] != level_req[r]);
               if (hit) gr_m[r] = t[15:0];
               bus_read(OFF_GR_A + 8'(4 * r), d, rs);
               check("capture", d, gr_m[r]);
            end
         end
      end
      // buffer modes silence fields c and d
      bus_write(OFF_MODE, 32'h3, rs);
      bus_write(OFF_CTL_LO, 32'hAA, rs);
      bus_read(OFF_MODE, d, rs);
      check("mode", d, 3);
      t = rnd();
      count_in <= t[15:0];
      level_req <= ~level_req;
      repeat (4) @(posedge clk_sys);
      for (int r = 2; r < 4; r++) begin
         bus_read(OFF_GR_A + 8'(4 * r), d, rs);
         check("buffered", d, gr_m[r]);
      end
      bus_write(OFF_CTL_LO, 32'h33, rs);
      repeat (3) @(posedge clk_sys);
      check("buf_oe", timer_pin_oe, 0);
      bus_write(OFF_MODE, 32'h0, rs);
      repeat (3) @(posedge clk_sys);
      check("unbuf_oe", timer_pin_oe, 4'hC);
      bus_read(OFF_STATUS, d, rs);
      check("status", d, 32'hC << STAT_OE_LSB);
      finish_test();
   end
endmodule

bind timer_ch4_io_control timer_io_monitor mon (.clk_sys, .reset, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .count_in, .timer_pin_out, .timer_pin_oe);
`default_nettype wire
